// File: rtl/tts_defines.svh
`ifndef TTS_DEFINES_SVH
`define TTS_DEFINES_SVH

// ==========================================================
// instruction encoding
`define TTS_W1_PREFIX   8'hb8
`define TTS_W1_SUFFIX   4'h6
`define TTS_W2_PREFIX   4'h0
`define TTS_W2_SUFFIX   4'he

// ==========================================================
// field positions
`define TTS_PFX_HI      15
`define TTS_PFX_LO      8
`define TTS_HI_NIB_HI   15
`define TTS_HI_NIB_LO   12
`define TTS_MID_NIB_HI  11
`define TTS_MID_NIB_LO  8
`define TTS_FLD_HI      7
`define TTS_FLD_LO      4
`define TTS_SUF_HI      3
`define TTS_SUF_LO      0

// ==========================================================
// steps and reset values
`define TTS_PTR_STEP    32'h0000_0001
`define TTS_CNT_STEP    16'h0001
`define TTS_RST_ADDR    32'h0000_0000
`define TTS_RST_BYTE    8'h00
`define TTS_RST_CNT     16'h0000
`define TTS_RST_FIELD   4'h0

`endif

// File: rtl/tts_pkg.sv
package tts_pkg;

  // ==========================================================
  // address representation
  typedef enum logic [1:0] {
    mode_compact   = 2'h0,
    mode_segmented = 2'h1,
    mode_linear    = 2'h2
  } addr_mode_t;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_src  = 4'h2,
    st_tbl  = 4'h4,
    st_upd  = 4'h8
  } state_t;

  // ==========================================================
  // decoded register selectors
  typedef struct packed {
    logic [3:0] string_pointer_field;
    logic [3:0] table_base_field;
    logic [3:0] cnt_field;
  } fields_t;

  // ==========================================================
  // condition flags written by the instruction
  typedef struct packed {
    logic null_result;
    logic count_done;
  } flags_t;

endpackage

// File: rtl/tts_decode.sv
`timescale 1ns/1ps
`include "tts_defines.svh"

module tts_decode
(
  // instruction words
  input  wire logic [15:0]     i_word1,
  input  wire logic [15:0]     i_word2,
  // decode result
  output logic                 o_valid,
  output tts_pkg::fields_t     o_fields
);

  logic w1_ok;
  logic w2_ok;

  // pointer or table selector zero would mean no indirect register, so it is refused
  assign w1_ok = (i_word1[`TTS_PFX_HI:`TTS_PFX_LO] == `TTS_W1_PREFIX)
              && (i_word1[`TTS_FLD_HI:`TTS_FLD_LO] != `TTS_RST_FIELD)
              && (i_word1[`TTS_SUF_HI:`TTS_SUF_LO] == `TTS_W1_SUFFIX);
  assign w2_ok = (i_word2[`TTS_HI_NIB_HI:`TTS_HI_NIB_LO] == `TTS_W2_PREFIX)
              && (i_word2[`TTS_FLD_HI:`TTS_FLD_LO] != `TTS_RST_FIELD)
              && (i_word2[`TTS_SUF_HI:`TTS_SUF_LO] == `TTS_W2_SUFFIX);

  assign o_valid = w1_ok && w2_ok;
  assign o_fields.string_pointer_field = i_word1[`TTS_FLD_HI:`TTS_FLD_LO];
  assign o_fields.table_base_field     = i_word2[`TTS_FLD_HI:`TTS_FLD_LO];
  assign o_fields.cnt_field            = i_word2[`TTS_MID_NIB_HI:`TTS_MID_NIB_LO];

endmodule // tts_decode

// File: rtl/translate_test_scan_repeat.sv
`timescale 1ns/1ps
`include "tts_defines.svh"

module translate_test_scan_repeat
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // instruction issue
  input  wire logic                 i_start,
  input  wire logic [15:0]          i_word1,
  input  wire logic [15:0]          i_word2,
  input  wire tts_pkg::addr_mode_t  i_mode,
  // operand register values, sampled at start
  input  wire logic [31:0]          i_ptr_val,
  input  wire logic [31:0]          i_tbl_val,
  input  wire logic [15:0]          i_cnt_val,
  // interrupt request
  input  wire logic                 i_irq_pending,
  // byte read port
  output logic                      o_mem_req,
  output logic [31:0]               o_mem_addr,
  input  wire logic                 i_mem_ack,
  input  wire logic [7:0]           i_mem_data,
  // register write-back
  output tts_pkg::fields_t          o_fields,
  output logic                      o_wb,
  output logic [31:0]               o_ptr,
  output logic [15:0]               o_cnt,
  output logic [7:0]                o_result,
  output tts_pkg::flags_t           o_flags,
  // status
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_interrupted,
  output logic                      o_illegal,
  output logic                      o_exception
);

  // ==========================================================
  // address arithmetic
  function automatic logic [31:0] addr_add(input logic [31:0]         base,
                                           input logic [31:0]         off,
                                           input tts_pkg::addr_mode_t mode);
    logic [15:0] low;
    low = base[15:0] + off[15:0];
    case (mode)
      tts_pkg::mode_compact:   addr_add = {16'h0000, low};
      // segment number is carried, only the offset wraps
      tts_pkg::mode_segmented: addr_add = {base[31:16], low};
      tts_pkg::mode_linear:    addr_add = base + off;
      default:                 addr_add = base + off;
    endcase
  endfunction

  // ==========================================================
  // decode
  logic             dec_valid;
  tts_pkg::fields_t dec_fields;

  tts_decode u_decode
  (
    .i_word1  (i_word1),
    .i_word2  (i_word2),
    .o_valid  (dec_valid),
    .o_fields (dec_fields)
  );

  // ==========================================================
  // state
  tts_pkg::state_t     state_q;
  tts_pkg::addr_mode_t mode_q;
  logic [31:0]         tbl_q;
  logic                mem_req_q;
  logic [31:0]         mem_addr_q;
  logic                wb_q;
  logic [31:0]         ptr_q;
  logic [15:0]         cnt_q;
  logic [7:0]          result_q;
  tts_pkg::flags_t     flags_q;
  tts_pkg::fields_t    fields_q;
  logic                busy_q;
  logic                done_q;
  logic                intr_q;
  logic                illegal_q;
  logic                exc_q;
  logic                accept;
  logic                src_ack;
  logic                tbl_ack;
  logic                finish;

  assign accept  = (state_q == tts_pkg::st_idle) && i_start && dec_valid;
  assign src_ack = (state_q == tts_pkg::st_src) && i_mem_ack;
  assign tbl_ack = (state_q == tts_pkg::st_tbl) && i_mem_ack;
  assign finish  = (result_q != `TTS_RST_BYTE) || (cnt_q == `TTS_RST_CNT);

  // ==========================================================
  // sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_q <= tts_pkg::st_idle;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      intr_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      intr_q <= 1'b0;
      case (state_q)
        tts_pkg::st_idle:
        begin
          if (accept)
          begin
            state_q <= tts_pkg::st_src;
            busy_q  <= 1'b1;
          end
        end
        tts_pkg::st_src:
        begin
          if (i_mem_ack)
            state_q <= tts_pkg::st_tbl;
        end
        tts_pkg::st_tbl:
        begin
          if (i_mem_ack)
            state_q <= tts_pkg::st_upd;
        end
        tts_pkg::st_upd:
        begin
          if (finish)
          begin
            state_q <= tts_pkg::st_idle;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
          else if (i_irq_pending)
          begin
            // leave between passes; the updated registers are already written back
            state_q <= tts_pkg::st_idle;
            busy_q  <= 1'b0;
            intr_q  <= 1'b1;
          end
          else
            state_q <= tts_pkg::st_src;
        end
        default:
        begin
          state_q <= tts_pkg::st_idle;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // memory requests
  // req stays high from the string byte straight into the table byte
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= `TTS_RST_ADDR;
    end
    else if (accept)
    begin
      mem_req_q  <= 1'b1;
      mem_addr_q <= i_ptr_val;
    end
    else if (src_ack)
      mem_addr_q <= addr_add(tbl_q, {24'h000000, i_mem_data}, mode_q);
    else if (tbl_ack)
      mem_req_q  <= 1'b0;
    else if ((state_q == tts_pkg::st_upd) && !finish && !i_irq_pending)
    begin
      mem_req_q  <= 1'b1;
      mem_addr_q <= ptr_q;
    end
  end

  // ==========================================================
  // operands; table base loads only at issue
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      mode_q   <= tts_pkg::mode_compact;
      tbl_q    <= `TTS_RST_ADDR;
      fields_q <= '0;
    end
    else if (accept)
    begin
      mode_q   <= i_mode;
      tbl_q    <= i_tbl_val;
      fields_q <= dec_fields;
    end
  end

  // ==========================================================
  // per-pass update
  // a zero count wraps to all ones, which gives the 65536-byte scan
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ptr_q    <= `TTS_RST_ADDR;
      cnt_q    <= `TTS_RST_CNT;
      result_q <= `TTS_RST_BYTE;
      flags_q  <= '0;
      wb_q     <= 1'b0;
    end
    else
    begin
      wb_q <= 1'b0;
      if (accept)
      begin
        ptr_q <= i_ptr_val;
        cnt_q <= i_cnt_val;
      end
      else if (tbl_ack)
      begin
        result_q            <= i_mem_data;
        ptr_q               <= addr_add(ptr_q, `TTS_PTR_STEP, mode_q);
        cnt_q               <= cnt_q - `TTS_CNT_STEP;
        flags_q.null_result <= (i_mem_data == `TTS_RST_BYTE);
        flags_q.count_done  <= (cnt_q == `TTS_CNT_STEP);
        wb_q                <= 1'b1;
      end
    end
  end

  // ==========================================================
  // issue errors; the instruction itself never faults
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      illegal_q <= 1'b0;
      exc_q     <= 1'b0;
    end
    else
    begin
      illegal_q <= (state_q == tts_pkg::st_idle) && i_start && !dec_valid;
      exc_q     <= 1'b0;
    end
  end

  assign o_mem_req     = mem_req_q;
  assign o_mem_addr    = mem_addr_q;
  assign o_fields      = fields_q;
  assign o_wb          = wb_q;
  assign o_ptr         = ptr_q;
  assign o_cnt         = cnt_q;
  assign o_result      = result_q;
  assign o_flags       = flags_q;
  assign o_busy        = busy_q;
  assign o_done        = done_q;
  assign o_interrupted = intr_q;
  assign o_illegal     = illegal_q;
  assign o_exception   = exc_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  src_fetch_a: assert property ((state_q == tts_pkg::st_src) |->
      (mem_req_q && mem_addr_q == ptr_q))
    else $error("string fetch not at pointer");
  tbl_address_a: assert property (src_ack |=> (mem_req_q && mem_addr_q ==
      addr_add(tbl_q, {24'h000000, $past(i_mem_data)}, mode_q)))
    else $error("table address wrong");
  result_load_a: assert property (tbl_ack |=> (wb_q && result_q == $past(i_mem_data)))
    else $error("result byte not loaded");
  ptr_step_a: assert property (tbl_ack |=>
      (ptr_q == addr_add($past(ptr_q), `TTS_PTR_STEP, mode_q)))
    else $error("pointer not advanced by one");
  cnt_step_a: assert property (tbl_ack |=> (cnt_q == $past(cnt_q) - `TTS_CNT_STEP))
    else $error("counter not decremented");
  scan_stop_a: assert property (((state_q == tts_pkg::st_upd) && finish) |=>
      (done_q && state_q == tts_pkg::st_idle && !busy_q))
    else $error("scan did not stop");
  scan_repeat_a: assert property (((state_q == tts_pkg::st_upd) && !finish &&
      !i_irq_pending) |=> (state_q == tts_pkg::st_src) ##1 (mem_req_q && !done_q))
    else $error("scan did not repeat");
  count_wrap_a: assert property ((tbl_ack && cnt_q == `TTS_RST_CNT) |=>
      (cnt_q == 16'hffff && !flags_q.count_done))
    else $error("zero count not treated as 65536");
  tbl_hold_a: assert property ((state_q != tts_pkg::st_idle) |=> $stable(tbl_q))
    else $error("table base changed");
  pass_irq_a: assert property (((state_q == tts_pkg::st_upd) && !finish &&
      i_irq_pending) |=> (intr_q && state_q == tts_pkg::st_idle && !mem_req_q))
    else $error("interrupt not taken after pass");
  null_flag_a: assert property (wb_q |->
      (flags_q.null_result == (result_q == `TTS_RST_BYTE)))
    else $error("null flag wrong");
  count_flag_a: assert property (wb_q |->
      (flags_q.count_done == (cnt_q == `TTS_RST_CNT)))
    else $error("count flag wrong");
  // the words may change once the start has been taken, so judge the issued ones
  decode_issue_a: assert property (((state_q == tts_pkg::st_idle) && i_start) |=>
      ($past(dec_valid) ? (state_q == tts_pkg::st_src) : illegal_q))
    else $error("decode issue wrong");
  resume_keep_a: assert property (intr_q |->
      ($stable(ptr_q) && $stable(cnt_q) && $stable(result_q)))
    else $error("state lost on interrupt");
  no_fault_a: assert property (busy_q |-> !exc_q)
    else $error("exception raised");

  found_cov: cover property (done_q && result_q != `TTS_RST_BYTE);
  exhaust_cov: cover property (done_q && flags_q.count_done && flags_q.null_result);
  irq_cov: cover property (intr_q);
  multi_pass_cov: cover property (wb_q ##[1:10] wb_q);

endmodule // translate_test_scan_repeat

// File: bench/tts_mem_model.sv
`timescale 1ns/1ps

// ==========================================================
// byte memory answering the scan's read port
module tts_mem_model
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // wait-state knob
  input  wire logic        i_slow,
  // read port
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  output logic             o_ack,
  output logic [7:0]       o_data
);
  logic [7:0] mem [logic [31:0]];
  logic [1:0] wait_q;
  logic [7:0] junk_q;

  // unwritten places read as zero, so short tables are legal
  function automatic logic [7:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction

  // ack in the cycle req rises when no wait is owed
  assign o_ack = i_req && (wait_q == 2'h0);

  // data line churns outside an ack so stale bytes never look valid
  always_comb o_data = o_ack ? rd(i_addr) : junk_q;

  always_ff @(posedge i_clk)
  begin
    junk_q <= (!i_rstn) ? 8'h5a : junk_q + 8'h53;
    if (!i_rstn)
      wait_q <= 2'h0;
    else if (o_ack)
      wait_q <= i_slow ? 2'($urandom_range(3)) : 2'h0;
    else if (i_req && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
  end
endmodule // tts_mem_model

// File: bench/tb_translate_test_scan_repeat.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_translate_test_scan_repeat;
  typedef struct packed {
    logic [31:0]      ptr;
    logic [15:0]      cnt;
    logic [7:0]       res;
    tts_pkg::flags_t  fl;
    tts_pkg::fields_t fd;
    logic [1:0]       kind;
  } note_t;

  logic                i_clk = 1'b0, i_rstn = 1'b0, i_start = 1'b0, i_irq_pending = 1'b0;
  logic                slow = 1'b0, end_due = 1'b0;
  logic [15:0]         i_word1 = 16'h0000, i_word2 = 16'h0000, i_cnt_val = 16'h0000, cnt;
  logic [31:0]         i_ptr_val = 32'h0, i_tbl_val = 32'h0, ptr, tbl, o_mem_addr, ea;
  tts_pkg::addr_mode_t i_mode = tts_pkg::mode_compact;
  logic                o_mem_req, i_mem_ack, o_wb, o_busy, o_done, o_interrupted;
  logic                o_illegal, o_exception;
  logic [7:0]          i_mem_data, o_result;
  logic [15:0]         w1, w2, o_cnt;
  logic [31:0]         o_ptr;
  logic [1:0]          end_k;
  tts_pkg::fields_t    o_fields, fd;
  tts_pkg::flags_t     o_flags;
  note_t               nq[$], e;
  logic [31:0]         aq[$];
  logic [31:0]         bad [6] = '{32'hb946035e, 32'hb806035e, 32'hb842035e,
                                   32'hb846135e, 32'hb846030e, 32'hb846035f};
  int                  n_fail = 0, n_checks = 0;

  always #50 i_clk = ~i_clk;

  translate_test_scan_repeat u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start),
    .i_word1(i_word1), .i_word2(i_word2), .i_mode(i_mode), .i_ptr_val(i_ptr_val),
    .i_tbl_val(i_tbl_val), .i_cnt_val(i_cnt_val), .i_irq_pending(i_irq_pending),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data), .o_fields(o_fields), .o_wb(o_wb), .o_ptr(o_ptr), .o_cnt(o_cnt),
    .o_result(o_result), .o_flags(o_flags), .o_busy(o_busy), .o_done(o_done),
    .o_interrupted(o_interrupted), .o_illegal(o_illegal), .o_exception(o_exception));

  tts_mem_model u_mem (.i_clk(i_clk), .i_rstn(i_rstn), .i_slow(slow), .i_req(o_mem_req),
    .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_data(i_mem_data));

  // ==========================================================
  // expected address arithmetic
  function automatic logic [31:0] add(input logic [31:0] b, input logic [31:0] o,
                                      input tts_pkg::addr_mode_t m);
    logic [15:0] lo;
    lo = b[15:0] + o[15:0];
    if (m == tts_pkg::mode_compact) return {16'h0000, lo};
    if (m == tts_pkg::mode_segmented) return {b[31:16], lo};
    return b + o;
  endfunction

  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // monitor: compares outputs against the oldest note
  always @(posedge i_clk)
  begin
    #1;
    if (o_mem_req === 1'b1 && i_mem_ack === 1'b1)
    begin
      ea = (aq.size() > 0) ? aq.pop_front() : 32'hxxxx_xxxx;
      `CHK("mem_addr", ea, o_mem_addr)
    end
    if (end_due)
    begin
      `CHK("end_kind", end_k, {o_interrupted, o_done})
      end_due = 1'b0;
    end
    if (o_wb === 1'b1)
    begin
      e = (nq.size() > 0) ? nq.pop_front() : 'x;
      `CHK("ptr", e.ptr, o_ptr)
      `CHK("cnt", e.cnt, o_cnt)
      `CHK("result", e.res, o_result)
      `CHK("null_flag", e.fl.null_result, o_flags.null_result)
      `CHK("count_flag", e.fl.count_done, o_flags.count_done)
      `CHK("fields", e.fd, o_fields)
      `CHK("exception", 1'b0, o_exception)
      end_k = e.kind;
      end_due = 1'b1;
    end
  end

  // ==========================================================
  // operands, encoding and memory image for one scenario
  task automatic setup(input logic [31:0] p, input logic [15:0] c,
                       input tts_pkg::addr_mode_t m, input int hit);
    logic [3:0] sp, tb, cf;
    sp = 4'(1 + $urandom_range(14));
    tb = sp % 4'hf + 4'h1;
    cf = tb % 4'hf + 4'h1;
    w1 = {8'hb8, sp, 4'h6};
    w2 = {4'h0, cf, tb, 4'he};
    fd = {sp, tb, cf};
    ptr = p;
    tbl = p ^ 32'h0000_8000;
    cnt = c;
    u_mem.mem.delete();
    for (int i = 0; i < 256; i++) u_mem.mem[add(tbl, i, m)] = 8'h00;
    u_mem.mem[add(tbl, 32'hff, m)] = 8'(1 + $urandom_range(254));
    for (int i = 0; i < 8; i++) u_mem.mem[add(ptr, i, m)] = (i == hit) ? 8'hff : 8'($urandom_range(254));
  endtask

  task automatic scan(input tts_pkg::addr_mode_t m, input logic irq, input logic ign);
    logic [31:0] p, ta;
    logic [15:0] c;
    logic [7:0]  y;
    logic [1:0]  k;
    int          i;
    p = ptr;
    c = cnt;
    k = 2'b00;
    while (k == 2'b00)
    begin
      aq.push_back(p);
      ta = add(tbl, {24'h0, u_mem.rd(p)}, m);
      aq.push_back(ta);
      y = u_mem.rd(ta);
      p = add(p, 32'h1, m);
      c = c - 16'h1;
      // termination outranks a pending interrupt
      k = (y != 8'h00 || c == 16'h0) ? 2'b01 : (irq ? 2'b10 : 2'b00);
      nq.push_back({p, c, y, y == 8'h00, c == 16'h0, fd, k});
    end
    @(posedge i_clk);
    i_start <= 1'b1;
    i_word1 <= w1;
    i_word2 <= w2;
    i_mode <= m;
    i_ptr_val <= ptr;
    i_tbl_val <= tbl;
    i_cnt_val <= cnt;
    i_irq_pending <= irq;
    @(posedge i_clk);
    i_start <= 1'b0;
    if (ign)
    begin
      repeat (2) @(posedge i_clk);
      i_start <= 1'b1;
      i_ptr_val <= ~ptr;
      @(posedge i_clk);
      i_start <= 1'b0;
    end
    for (i = 0; i < 3000; i++)
    begin
      @(posedge i_clk);
      #2;
      if (o_busy !== 1'b1 && nq.size() == 0 && !end_due) break;
    end
    if (i == 3000)
    begin
      n_fail++;
      final_report();
    end
    ptr = p;
    cnt = c;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(61207));
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    #2;
    `CHK("busy_rst", 1'b0, o_busy)
    `CHK("req_rst", 1'b0, o_mem_req)
    foreach (bad[j])
    begin
      @(posedge i_clk);
      i_start <= 1'b1;
      {i_word1, i_word2} <= bad[j];
      @(posedge i_clk);
      i_start <= 1'b0;
      #2;
      `CHK("illegal", 1'b1, o_illegal)
      `CHK("busy_illegal", 1'b0, o_busy)
    end
    setup(32'h0000_fffd, 16'h0006, tts_pkg::mode_compact, -1);
    scan(tts_pkg::mode_compact, 1'b0, 1'b0);
    slow = 1'b1;
    setup({16'($urandom), 16'hfffe}, 16'h0008, tts_pkg::mode_segmented, 3);
    scan(tts_pkg::mode_segmented, 1'b0, 1'b1);
    setup(32'h0001_ffff, 16'h0001, tts_pkg::mode_linear, -1);
    scan(tts_pkg::mode_linear, 1'b0, 1'b0);
    setup($urandom, 16'h0000, tts_pkg::mode_linear, 2);
    scan(tts_pkg::mode_linear, 1'b0, 1'b0);
    slow = 1'b0;
    setup({16'h0000, 16'($urandom)}, 16'h0001, tts_pkg::mode_compact, 0);
    scan(tts_pkg::mode_compact, 1'b0, 1'b0);
    // re-issue after each break, carrying pointer and count forward
    setup({16'($urandom), 16'($urandom)}, 16'h0003, tts_pkg::mode_segmented, -1);
    repeat (3) scan(tts_pkg::mode_segmented, 1'b1, 1'b0);
    final_report();
  end
endmodule // tb_translate_test_scan_repeat
